/* irq_enable_priority_slice.sv */
// Top: wake-up enable, four priority levels, event status and interrupt
//
// Functional notes
// - Bit 0 of the wake enable register is the read/write low-power wake-up enable.
// - With the enable at one a pending wake-up request passes on to the processor.
// - With the enable at zero the wake-up request is blocked.
// - Enable register bits 15..1 read zero and ignore writes.
// - Priority register holds 3-bit levels at 14-12, 10-8, 6-4, 2-0; 7 highest, 0 off.
`timescale 1ns/1ns
module irq_enable_priority_slice
  import irq_slice_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Register port
  input  wire logic [irq_slice_pkg::ADDR_W-1:0] addr,
  input  wire logic [irq_slice_pkg::DATA_W-1:0] wrData,
  input  wire logic                         wrStrobe,
  input  wire logic                         rdStrobe,
  output logic      [irq_slice_pkg::DATA_W-1:0] rdData,
  // Wake-up request from the low-power wake-up source
  input  wire logic                         wakeReq,
  // Towards arbitration
  output logic                              wakeReqGated,
  output logic      [2:0]                   timer_one_level,
  output logic      [2:0]                   compare_one_level,
  output logic      [2:0]                   capture_one_level,
  output logic      [2:0]                   ext_irq_zero_level,
  // Interrupt
  output logic                              irq
);
  import irq_slice_pkg::*;

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  // Stored bits, decode strobes, synchroniser stages and read mux
  logic                 lowpower_wake_irq_en;
  logic [EVENT_W-1:0]   irqStatus;
  logic [EVENT_W-1:0]   irqMask;
  logic [EVENT_W-1:0]   events;
  logic                 wakeSync1;
  logic                 wakeSync2;
  logic                 wrEnable;
  logic                 wrPriority;
  logic                 wrStatus;
  logic                 wrMask;
  logic [DATA_W-1:0]    priorityWord;
  logic [DATA_W-1:0]    next_rdData;
  logic [2:0]           prevTimer;
  logic [2:0]           prevCompare;
  logic [2:0]           prevCapture;
  logic [2:0]           prevExt;

  // Write decode; an unmapped address raises no enable, so such a write
  // is simply dropped and the stored registers never see it
  always_comb begin
    wrEnable   = 1'b0;
    wrPriority = 1'b0;
    wrStatus   = 1'b0;
    wrMask     = 1'b0;
    if (wrStrobe && addr == ADDR_WAKE_IRQ_ENABLE) begin
      wrEnable = 1'b1;
    end else if (wrStrobe && addr == ADDR_IRQ_PRIORITY_BANK) begin
      wrPriority = 1'b1;
    end else if (wrStrobe && addr == ADDR_IRQ_STATUS) begin
      wrStatus = 1'b1;
    end else if (wrStrobe && addr == ADDR_IRQ_MASK) begin
      wrMask = 1'b1;
    end
  end

  // Only bit 0 is stored; upper bits of a write are dropped
  // Keeping the other fifteen bits out of storage means they can never
  // read back as anything but zero, whatever software writes there
  always_ff @(posedge clk) begin
    if (rst) begin
      lowpower_wake_irq_en <= WAKE_EN_RESET;
    end else if (wrEnable) begin
      lowpower_wake_irq_en <= wrData[WAKE_EN_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Priority fields
  // ----------------------------------------------------------------------
  // Four copies of one field; all share the word write strobe, and each
  // takes its own three bits, so the gap bits never reach storage
  level_field #(.LSB(TIMER_ONE_LSB), .RESET(LEVEL_RESET)) uTimer (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (wrPriority),
    .wrData (wrData),
    .level  (timer_one_level)
  );
  level_field #(.LSB(COMPARE_ONE_LSB), .RESET(LEVEL_RESET)) uCompare (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (wrPriority),
    .wrData (wrData),
    .level  (compare_one_level)
  );
  level_field #(.LSB(CAPTURE_ONE_LSB), .RESET(LEVEL_RESET)) uCapture (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (wrPriority),
    .wrData (wrData),
    .level  (capture_one_level)
  );
  level_field #(.LSB(EXT_ZERO_LSB), .RESET(LEVEL_RESET)) uExt (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (wrPriority),
    .wrData (wrData),
    .level  (ext_irq_zero_level)
  );

  // Gaps at 15, 11, 7, 3 are tied low
  assign priorityWord = {1'b0, timer_one_level, 1'b0, compare_one_level,
                         1'b0, capture_one_level, 1'b0, ext_irq_zero_level};

  // ----------------------------------------------------------------------
  // Wake-up path
  // ----------------------------------------------------------------------
  // Request comes from an asynchronous analog source, so synchronise it
  // Only the second stage feeds logic; the first may go metastable
  // Cost: two cycles of latency before the gate sees a new request
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeSync1 <= 1'b0;
      wakeSync2 <= 1'b0;
    end else begin
      wakeSync1 <= wakeReq;
      wakeSync2 <= wakeSync1;
    end
  end

  // Enable gates the request toward the core
  assign wakeReqGated = wakeSync2 & lowpower_wake_irq_en;

  // ----------------------------------------------------------------------
  // Event status and interrupt
  // ----------------------------------------------------------------------
  // Previous levels, to flag a priority field that changed to zero
  // Reset loads them with the reset level so no false event follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      prevTimer   <= LEVEL_RESET;
      prevCompare <= LEVEL_RESET;
      prevCapture <= LEVEL_RESET;
      prevExt     <= LEVEL_RESET;
    end else begin
      prevTimer   <= timer_one_level;
      prevCompare <= compare_one_level;
      prevCapture <= capture_one_level;
      prevExt     <= ext_irq_zero_level;
    end
  end

  // Events: gated wake request, and each source newly disabled (level 0)
  assign events = {wakeReqGated,
                   (timer_one_level == 3'h0) && (prevTimer != 3'h0),
                   (compare_one_level == 3'h0) && (prevCompare != 3'h0),
                   (capture_one_level == 3'h0) && (prevCapture != 3'h0),
                   (ext_irq_zero_level == 3'h0) && (prevExt != 3'h0)};

  // Sticky status, write one to clear; a new event wins over the clear
  // A clear that meets a fresh event in one cycle leaves the bit set,
  // so software never loses an event it has not yet seen
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus <= STATUS_RESET;
    end else if (wrStatus) begin
      irqStatus <= (irqStatus & ~wrData[EVENT_W-1:0]) | events;
    end else begin
      irqStatus <= irqStatus | events;
    end
  end

  // Mask register, one bit per status bit
  always_ff @(posedge clk) begin
    if (rst) begin
      irqMask <= MASK_RESET;
    end else if (wrMask) begin
      irqMask <= wrData[EVENT_W-1:0];
    end
  end

  // Level output while any unmasked status bit is set
  // Stays high until software clears the status bit or masks it
  assign irq = |(irqStatus & irqMask);

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Unmapped addresses read zero
  // Decode is a priority chain; the four offsets never overlap, so the
  // order only matters for readability
  always_comb begin
    next_rdData = 16'h0000;
    if (addr == ADDR_WAKE_IRQ_ENABLE) begin
      next_rdData = {15'h0000, lowpower_wake_irq_en};
    end else if (addr == ADDR_IRQ_PRIORITY_BANK) begin
      next_rdData = priorityWord;
    end else if (addr == ADDR_IRQ_STATUS) begin
      next_rdData = {11'h000, irqStatus};
    end else if (addr == ADDR_IRQ_MASK) begin
      next_rdData = {11'h000, irqMask};
    end
  end

  // Data stands only in the cycle after the read strobe
  // Limitation: a master that misses that cycle reads zero, not stale data
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= 16'h0000;
    end else if (rdStrobe) begin
      rdData <= next_rdData;
    end else begin
      rdData <= 16'h0000;
    end
  end
endmodule // irq_enable_priority_slice

/* irq_enable_priority_slice_tb_top.sv */
// Testbench: register, wake-up and interrupt scenarios for the slice
`timescale 1ns/1ns
module irq_enable_priority_slice_tb_top;
  import irq_slice_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, wrStrobe = 1'b0, rdStrobe = 1'b0, fire = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  holdLen = 8'h00;
  logic [15:0] wrData = 16'h0000, rdData, got;
  logic        wakeReq, wakeReqGated, irq;
  logic [2:0]  tLv, cLv, pLv, eLv;
  int          errCount = 0, testsRun = 0;
  always #50 clk = ~clk;
  irq_enable_priority_slice irq_enable_priority_slice_inst (.clk(clk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .wakeReq(wakeReq), .wakeReqGated(wakeReqGated), .timer_one_level(tLv),
    .compare_one_level(cLv), .capture_one_level(pLv), .ext_irq_zero_level(eLv), .irq(irq));
  wake_source wake_source_inst (.clk(clk), .fire(fire), .holdLen(holdLen), .wakeReq(wakeReq));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    testsRun++;
    if (g !== e) begin
      errCount++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrapUp;
    $display("Checks %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Bus cycles; a write leaves on its edge so a read can follow with no gap
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 got = rdData;
    @(posedge clk);
  endtask
  task automatic resetValues;
    rd(ADDR_WAKE_IRQ_ENABLE);
    chk(got, 16'h0000);
    rd(ADDR_IRQ_PRIORITY_BANK);
    chk(got, 16'h4444);
    chk({4'h0, tLv, cLv, pLv, eLv}, 16'h0924);
  endtask
  // Reset in mid-run with non-reset levels and the enable set
  task automatic midReset;
    @(posedge clk);
    wr(ADDR_IRQ_PRIORITY_BANK, 16'h1235);
    rd(ADDR_IRQ_PRIORITY_BANK);
    chk(got, 16'h1235);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    resetValues();
  endtask
  task automatic enableBits;
    wr(ADDR_WAKE_IRQ_ENABLE, 16'hFFFF);
    rd(ADDR_WAKE_IRQ_ENABLE);
    chk(got, 16'h0001);
    wr(ADDR_WAKE_IRQ_ENABLE, 16'hFFFE);
    rd(ADDR_WAKE_IRQ_ENABLE);
    chk(got, 16'h0000);
    rd(4'hF);
    chk(got, 16'h0000);
  endtask
  task automatic levels;
    wr(ADDR_IRQ_PRIORITY_BANK, 16'h7654);
    rd(ADDR_IRQ_PRIORITY_BANK);
    chk(got, 16'h7654);
    chk({4'h0, tLv, cLv, pLv, eLv}, 16'h0FAC);
    wr(ADDR_IRQ_PRIORITY_BANK, 16'hFFFF);
    rd(ADDR_IRQ_PRIORITY_BANK);
    chk(got, 16'h7777);
    wr(ADDR_IRQ_PRIORITY_BANK, 16'h0000);
    @(posedge clk);
    rd(ADDR_IRQ_STATUS);
    chk(got, 16'h000F);
  endtask
  // Wake request blocked, then passed on to the interrupt and cleared
  task automatic wakePath;
    logic seen = 1'b0;
    int n = 0;
    wr(ADDR_IRQ_MASK, 16'h0010);
    holdLen <= 8'h06;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (12) @(negedge clk) seen |= wakeReqGated;
    chk({15'h0, seen}, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    @(posedge clk);
    wr(ADDR_WAKE_IRQ_ENABLE, 16'h0001);
    holdLen <= 8'h28;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk);
    rd(ADDR_WAKE_IRQ_ENABLE);
    chk(got, 16'h0001);
    while (wakeReqGated !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (n == 8) begin
      errCount++;
      wrapUp();
    end
    repeat (3) @(negedge clk);
    chk({15'h0, irq}, 16'h0001);
    repeat (45) @(posedge clk);
    wr(ADDR_IRQ_STATUS, 16'h001F);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    resetValues();
    enableBits();
    levels();
    wakePath();
    midReset();
    wrapUp();
  end
endmodule // irq_enable_priority_slice_tb_top

/* irq_slice_checker.sv */
// Checker: port assertions for the interrupt enable and priority slice
`timescale 1ns/1ns
module irq_slice_checker
  import irq_slice_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic        wrStrobe,
  input wire logic        rdStrobe,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wrData,
  input wire logic [15:0] rdData,
  // Wake levels
  input wire logic        wakeReq,
  input wire logic        wakeReqGated,
  // Levels
  input wire logic [2:0]  timer_one_level,
  input wire logic [2:0]  compare_one_level,
  input wire logic [2:0]  capture_one_level,
  input wire logic [2:0]  ext_irq_zero_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Levels packed as they read back, gaps at 15, 11, 7, 3
  wire logic [15:0] levelWord = {1'b0, timer_one_level, 1'b0, compare_one_level,
                                 1'b0, capture_one_level, 1'b0, ext_irq_zero_level};
  logic enWr, prWr;
  assign enWr = wrStrobe && addr == ADDR_WAKE_IRQ_ENABLE;
  assign prWr = wrStrobe && addr == ADDR_IRQ_PRIORITY_BANK;

  property p_enRead;
    rdStrobe && addr == ADDR_WAKE_IRQ_ENABLE |=> rdData[15:1] == 15'h0000;
  endproperty
  a_enRead: assert property (p_enRead) else $error("enable upper bits not zero");
  property p_enTrip;
    enWr ##1 rdStrobe && addr == ADDR_WAKE_IRQ_ENABLE
      |=> rdData == {15'h0000, $past(wrData[0], 2)};
  endproperty
  a_enTrip: assert property (p_enTrip) else $error("enable bit lost");
  property p_prRead;
    rdStrobe && addr == ADDR_IRQ_PRIORITY_BANK |=> rdData == $past(levelWord);
  endproperty
  a_prRead: assert property (p_prRead) else $error("priority read wrong");
  property p_prWrite;
    prWr |=> levelWord == ($past(wrData) & 16'h7777);
  endproperty
  a_prWrite: assert property (p_prWrite) else $error("priority write wrong");
  property p_hold;
    !prWr |=> $stable(levelWord);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved without write");
  property p_blocked;
    enWr && !wrData[0] |=> !wakeReqGated;
  endproperty
  a_blocked: assert property (p_blocked) else $error("wake passed while disabled");
  property p_pass;
    wakeReq [*3] ##0 (rdStrobe && addr == ADDR_WAKE_IRQ_ENABLE) ##1 rdData[0]
      |-> wakeReqGated;
  endproperty
  a_pass: assert property (p_pass) else $error("wake blocked while enabled");
  property p_rstLv;
    $fell(rst) |-> levelWord == 16'h4444;
  endproperty
  a_rstLv: assert property (p_rstLv) else $error("reset levels wrong");
endmodule // irq_slice_checker

bind irq_enable_priority_slice irq_slice_checker irq_slice_checker_inst (.clk(clk), .rst(rst),
  .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .wakeReq(wakeReq), .wakeReqGated(wakeReqGated),
  .addr(addr), .wrData(wrData), .rdData(rdData), .timer_one_level(timer_one_level),
  .compare_one_level(compare_one_level), .capture_one_level(capture_one_level),
  .ext_irq_zero_level(ext_irq_zero_level));

/* irq_slice_pkg.sv */
// Package: register map, field layout and reset values of the interrupt slice
package irq_slice_pkg;
  // ----------------------------------------------------------------------
  // Register offsets (word addresses on the plain register port)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_WAKE_IRQ_ENABLE   = 4'h0;
  localparam logic [3:0] ADDR_IRQ_PRIORITY_BANK = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS        = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK          = 4'h3;
  localparam int         ADDR_W                 = 4;
  localparam int         DATA_W                 = 16;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int         WAKE_EN_BIT     = 0;
  localparam int         LEVEL_W         = 3;
  localparam int         NUM_LEVELS      = 4;
  localparam int         FIELD_STRIDE    = 4;
  localparam int         EXT_ZERO_LSB    = 0;
  localparam int         CAPTURE_ONE_LSB = 4;
  localparam int         COMPARE_ONE_LSB = 8;
  localparam int         TIMER_ONE_LSB   = 12;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] LEVEL_RESET     = 3'h4;
  localparam logic       WAKE_EN_RESET   = 1'h0;
  localparam logic [4:0] STATUS_RESET    = 5'h00;
  localparam logic [4:0] MASK_RESET      = 5'h00;
  localparam int         EVENT_W         = 5;
  localparam int         EV_WAKE         = 4;
endpackage

/* level_field.sv */
// One 3-bit priority level field with reset and word-write update
`timescale 1ns/1ns
module level_field #(
  parameter int                 LSB   = 0,
  parameter logic [2:0]         RESET = 3'h4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Write side
  input  wire logic             wrEn,
  input  wire logic [15:0]      wrData,
  // Stored level
  output logic      [2:0]       level
);
  // Level storage; a write replaces the whole field
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= RESET;
    end else if (wrEn) begin
      level <= wrData[LSB +: 3];
    end
  end
endmodule // level_field

/* wake_source.sv */
// Partner: low-power wake-up source holding its request level
`timescale 1ns/1ns
module wake_source (
  // Clock and command
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic [7:0] holdLen,
  // Request towards the slice
  output logic            wakeReq
);
  logic [7:0] left = 8'h00;
  // Long holds model a slow source; the level drops cleanly at the end
  always @(posedge clk) begin
    if (fire) left <= holdLen;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  assign wakeReq = (left != 8'h00);
endmodule // wake_source
